// File: pkg/adcd_map.vh
// constants for the daisy-chain serial port: frame lengths, write byte fields
// assumes inclusion by bare name from the design files
`ifndef ADCD_MAP_VH
`define ADCD_MAP_VH

// =====================================================================
// frame lengths in serial clocks per device
`define ADCD_RES_BITS      18
`define ADCD_STAT_BITS     6
`define ADCD_FRAME_STAT    24
`define ADCD_SHIFT_W       24

// =====================================================================
// register write layout: command byte then data byte
`define ADCD_WR_BITS       16
`define ADCD_CMD_MSB       15
`define ADCD_CMD_LSB       8
`define ADCD_DAT_MSB       7
`define ADCD_DAT_LSB       0
// command byte that addresses the configuration register (write, address 0x14)
`define ADCD_CMD_WR_CFG    8'h14
// configuration fields
`define ADCD_CFG_STAT_BIT  1
`define ADCD_CFG_RESET     8'hE1

// =====================================================================
// conversion time in ns and derived cycle count at MCLK
`define ADCD_MCLK_MHZ      100
`define ADCD_TCONV_NS      290
`define ADCD_TCONV_CYC     ((`ADCD_TCONV_NS * `ADCD_MCLK_MHZ + 999) / 1000)

`endif

// File: hdl/adcd_sync.v
// two-flop synchroniser for one level from outside the MCLK domain
// assumes an asynchronous active-low reset shared with the caller
`timescale 1ns/1ps

module adcd_sync
(
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // level in and out
  input  wire din,
  output wire dout
);

  reg meta_q;
  reg sync_q;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // adcd_sync

// File: hdl/adcd_chain_port.v
// daisy-chain serial port of a SAR converter, device side
// assumes the serial clock and chain pins arrive asynchronously to MCLK and
// that the conversion core hands a result over on a same-clock pulse
`timescale 1ns/1ps
`include "adcd_map.vh"

module adcd_chain_port
(
  // clock and reset
  input  wire        MCLK,
  input  wire        ARST_N,
  // chain pins
  input  wire        SCLK_PIN,
  input  wire        CONVERT_START,
  input  wire        CHAIN_DATA_IN,
  output reg         CHAIN_DATA_OUT,
  // conversion core
  input  wire        RESULT_VALID,
  input  wire [17:0] RESULT_DATA,
  input  wire [5:0]  STATUS_DATA,
  output reg         CONV_BUSY,
  output reg         CONV_START_PULSE,
  // configuration held for the core
  output reg  [7:0]  CFG_REG,
  output reg         CFG_WRITE_PULSE
);

  // =====================================================================
  // synchronised pins
  // index 2 serial clock, 1 convert_start, 0 chain_data_in; equal depth on all three
  // keeps data and clock edges in the same order as on the pins
  wire [2:0] pin_raw;
  wire [2:0] pin_sync;
  wire       sclk_s;
  wire       cnv_s;
  wire       sdi_s;

  assign pin_raw = {SCLK_PIN, CONVERT_START, CHAIN_DATA_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      adcd_sync u_sync
      (
        .clk    (MCLK),
        .arst_n (ARST_N),
        .din    (pin_raw[gi]),
        .dout   (pin_sync[gi])
      );
    end
  endgenerate

  assign sclk_s = pin_sync[2];
  assign cnv_s  = pin_sync[1];
  assign sdi_s  = pin_sync[0];

  reg sclk_prev_q;
  reg cnv_prev_q;

  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire cnv_rise  = cnv_s & ~cnv_prev_q;
  wire cnv_fall  = ~cnv_s & cnv_prev_q;

  // =====================================================================
  // state machine
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_CONV  = 2'b01;
  localparam [1:0] ST_READ  = 2'b10;

  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [23:0] shift_q;
  reg [23:0] shift_d;
  reg        out_d;
  reg        sample_q;
  reg        sample_d;
  reg [7:0]  cfg_d;
  reg        wr_pulse_d;

  // status bits follow the result only when enabled in the configuration;
  // with status off the result sits in the low 18 bits and is tapped at bit 16,
  // so upstream bits surface after 18 shifts and an 18-clock read stays aligned
  function [23:0] load_frame;
    input [17:0] res;
    input [5:0]  stat;
    input        stat_en;
    begin
      if (stat_en)
        load_frame = {res, stat};
      else
        load_frame = {6'h0_0, res};
    end
  endfunction

  wire stat_en = CFG_REG[`ADCD_CFG_STAT_BIT];

  always @*
  begin
    state_d    = state_q;
    shift_d    = shift_q;
    out_d      = CHAIN_DATA_OUT;
    sample_d   = sample_q;
    cfg_d      = CFG_REG;
    wr_pulse_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (cnv_rise)
        begin
          // write window closes here, then the conversion starts
          if (shift_q[`ADCD_CMD_MSB:`ADCD_CMD_LSB] == `ADCD_CMD_WR_CFG)
          begin
            cfg_d      = shift_q[`ADCD_DAT_MSB:`ADCD_DAT_LSB];
            wr_pulse_d = 1'b1;
          end
          shift_d = 24'h00_0000;
          out_d   = 1'b0;
          state_d = ST_CONV;
        end
        else
        begin
          if (sclk_rise)
            shift_d = {shift_q[22:0], sdi_s};
          // write bits pass on eight clocks late, so one 16-bit write
          // reaches every device of the chain in 8*(N+1) clocks
          if (sclk_fall)
            out_d = shift_q[`ADCD_DAT_MSB];
          else if (!sdi_s && !sclk_s && shift_q == 24'h00_0000)
            out_d = 1'b0;
        end
      end
      ST_CONV:
      begin
        out_d = 1'b0;
        if (cnv_fall)
          state_d = ST_IDLE;
        else if (RESULT_VALID)
        begin
          shift_d = load_frame(RESULT_DATA, STATUS_DATA, stat_en);
          out_d   = RESULT_DATA[17];
          state_d = ST_READ;
        end
      end
      ST_READ:
      begin
        if (cnv_fall)
        begin
          // readback ends with convert_start low; no register path exists
          shift_d = 24'h00_0000;
          out_d   = 1'b0;
          state_d = ST_IDLE;
        end
        else
        begin
          if (sclk_rise)
            sample_d = sdi_s;
          if (sclk_fall)
          begin
            // shift on falling edge so the bit holds across the next rising one
            shift_d = {shift_q[22:0], sample_q};
            if (stat_en)
              out_d = shift_q[22];
            else
              out_d = shift_q[16];
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // =====================================================================
  // registers
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q          <= ST_IDLE;
      shift_q          <= 24'h00_0000;
      sample_q         <= 1'b0;
      sclk_prev_q      <= 1'b0;
      cnv_prev_q       <= 1'b0;
      CHAIN_DATA_OUT   <= 1'b0;
      CONV_BUSY        <= 1'b0;
      CONV_START_PULSE <= 1'b0;
      CFG_REG          <= `ADCD_CFG_RESET;
      CFG_WRITE_PULSE  <= 1'b0;
    end
    else
    begin
      state_q          <= state_d;
      shift_q          <= shift_d;
      sample_q         <= sample_d;
      sclk_prev_q      <= sclk_s;
      cnv_prev_q       <= cnv_s;
      CHAIN_DATA_OUT   <= out_d;
      CONV_BUSY        <= (state_d == ST_CONV);
      CONV_START_PULSE <= (state_q == ST_IDLE) && cnv_rise;
      CFG_REG          <= cfg_d;
      CFG_WRITE_PULSE  <= wr_pulse_d;
    end
  end

endmodule // adcd_chain_port

// File: verification/adcd_host.sv
// host model for the chain: drives clock, start and data pins
// assumes one device whose output feeds back to the host
`timescale 1ns/1ps
// =====
// host pins
module adcd_host (
  // to device
  output logic sclk,
  output logic convert_start,
  output logic chain_data_in,
  // from device
  input  wire  chain_data_out
);
  // clock stands low outside frames
  initial {sclk, convert_start, chain_data_in} = 3'b000;
  task automatic shift(input int n, input logic [47:0] din, output logic [47:0] dout);
    dout = '0;
    // quarter-step offset keeps every pin edge clear of both MCLK edges
    #1.25;
    for (int i = n - 1; i >= 0; i--)
    begin
      chain_data_in = din[i];
      #62.5 sclk = 1'b1;
      dout[i] = chain_data_out;
      #62.5 sclk = 1'b0;
    end
    chain_data_in = 1'b0;
  endtask
endmodule // adcd_host

// File: verification/adcd_chain_port_assertions.sv
// port checker for the chain serial port
// assumes a serial clock far slower than MCLK
`timescale 1ns/1ps
// =====
// checker
module adcd_chk (
  // clock and reset
  input wire        MCLK,
  input wire        ARST_N,
  // pins and core side
  input wire        SCLK_PIN,
  input wire        CONVERT_START,
  input wire        CHAIN_DATA_OUT,
  input wire        RESULT_VALID,
  input wire [17:0] RESULT_DATA,
  input wire        CONV_BUSY,
  input wire        CONV_START_PULSE,
  input wire [7:0]  CFG_REG,
  input wire        CFG_WRITE_PULSE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  reg msb_q;
  always @(posedge MCLK) msb_q <= RESULT_DATA[17];
  sequence s_done; RESULT_VALID && CONV_BUSY; endsequence
  a_msb_out:
    assert property (s_done |=> CHAIN_DATA_OUT == msb_q) else $error("msb");
  a_busy_clear:
    assert property (s_done |=> !CONV_BUSY) else $error("busy");
  a_busy_low:
    assert property (CONV_BUSY |-> !CHAIN_DATA_OUT) else $error("low");
  a_start_pulse:
    assert property ($rose(CONVERT_START) |-> ##[2:4] CONV_START_PULSE) else $error("start");
  a_pulse_one:
    assert property (CONV_START_PULSE |=> !CONV_START_PULSE && CONV_BUSY) else $error("pulse");
  a_cfg_hold:
    assert property ($changed(CFG_REG) |-> CFG_WRITE_PULSE && CONV_START_PULSE) else $error("cfg");
  a_rise_stable:
    assert property ($rose(SCLK_PIN) |-> ##1 $stable(CHAIN_DATA_OUT)[*3]) else $error("rise");
  a_fall_move:
    assert property ($changed(CHAIN_DATA_OUT) && CONVERT_START && $past(CONVERT_START)
      && !CONV_BUSY && !$past(CONV_BUSY) |-> !SCLK_PIN) else $error("fall");
endmodule // adcd_chk
bind adcd_chain_port adcd_chk chk_i (.MCLK(MCLK), .ARST_N(ARST_N), .SCLK_PIN(SCLK_PIN),
  .CONVERT_START(CONVERT_START), .CHAIN_DATA_OUT(CHAIN_DATA_OUT),
  .RESULT_VALID(RESULT_VALID), .RESULT_DATA(RESULT_DATA), .CONV_BUSY(CONV_BUSY),
  .CONV_START_PULSE(CONV_START_PULSE), .CFG_REG(CFG_REG), .CFG_WRITE_PULSE(CFG_WRITE_PULSE));

// File: verification/adcd_chain_port_tb.sv
// bench: reset, config writes through the chain, two readback frames
// assumes adcd_host as far end and adcd_chk bound to the port
`timescale 1ns/1ps
module adcd_chain_port_tb;
  logic mclk = 0, arst_n = 0, rv = 0;
  logic [17:0] rd = '0;
  logic [5:0] sd = '0;
  wire sclk, convert_start, chain_data_in, chain_data_out, busy, csp, cwp;
  wire [7:0] cfg;
  int errors = 0, tests_run = 0;
  adcd_host host (.sclk(sclk), .convert_start(convert_start), .chain_data_in(chain_data_in), .chain_data_out(chain_data_out));
  adcd_chain_port uut (.MCLK(mclk), .ARST_N(arst_n), .SCLK_PIN(sclk),
    .CONVERT_START(convert_start), .CHAIN_DATA_IN(chain_data_in), .CHAIN_DATA_OUT(chain_data_out),
    .RESULT_VALID(rv), .RESULT_DATA(rd), .STATUS_DATA(sd), .CONV_BUSY(busy),
    .CONV_START_PULSE(csp), .CFG_REG(cfg), .CFG_WRITE_PULSE(cwp));
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic after_reset;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    repeat (5) @(negedge mclk);
    chk(48'({cfg, chain_data_out, busy, csp, cwp}), 48'h0000_0000_0E10);
  endtask
  // write bits with start low, then a start edge applies them; the device
  // hands every write bit on eight clocks later
  task automatic wr(input int n, input logic [47:0] bits, input logic [7:0] exp_cfg);
    logic [47:0] fwd;
    @(negedge mclk) host.shift(n, bits, fwd);
    @(negedge mclk) host.convert_start = 1'b1;
    repeat (8) @(negedge mclk);
    host.convert_start = 1'b0;
    repeat (8) @(negedge mclk);
    chk(fwd, bits >> 8);
    chk(48'(cfg), 48'(exp_cfg));
  endtask
  task automatic frame(input int n, input logic [47:0] din, input logic [47:0] exp);
    logic [47:0] got;
    @(negedge mclk) host.convert_start = 1'b1;
    repeat (8) @(negedge mclk);
    chk(48'({busy, chain_data_out}), 48'h0000_0000_0002);
    {rd, sd, rv} = {18'h2_B5C3, 6'h2D, 1'b1};
    @(negedge mclk) rv = 1'b0;
    repeat (2) @(negedge mclk);
    host.shift(n, din, got);
    repeat (6) @(negedge mclk);
    host.convert_start = 1'b0;
    chk(got, exp);
    repeat (4) @(negedge mclk);
    chk(48'(chain_data_out), 48'h0000_0000_0000);
  endtask
  initial
  begin
    after_reset;
    wr(24, 48'h0000_00A5_14E3, 8'hE3);
    frame(48, 48'h9C36_A500_0000, 48'hAD70_ED9C_36A5);
    wr(16, 48'h0000_0000_1500, 8'hE3);
    wr(16, 48'h0000_0000_14E1, 8'hE1);
    frame(36, 48'h0004_BC28_0000, 48'h000A_D70D_2F0A);
    results;
  end
  initial
  begin
    #200000;
    errors++;
    results;
  end
endmodule // adcd_chain_port_tb
